// ---- pkg/vaa_pkg.sv ----
// constants, types and register map of the virtual interrupt controller assist
// assumes a single clock domain shared with the guest access and core ports
package vaa_pkg;
	// --------------------------------------------------------------
	// control block registers (axi byte addresses)
	// --------------------------------------------------------------
	localparam int          AXI_AW        = 12;
	localparam logic [11:0] REG_CTRL      = 12'h060;
	localparam logic [11:0] REG_LEG_VEC   = 12'h064;
	localparam logic [11:0] REG_BAR_LO    = 12'h098;
	localparam logic [11:0] REG_BAR_HI    = 12'h09c;
	localparam logic [11:0] REG_BACK_LO   = 12'h0e0;
	localparam logic [11:0] REG_BACK_HI   = 12'h0e4;
	localparam logic [11:0] REG_LOG_LO    = 12'h0f0;
	localparam logic [11:0] REG_LOG_HI    = 12'h0f4;
	localparam logic [11:0] REG_PHY_LO    = 12'h0f8;
	localparam logic [11:0] REG_PHY_HI    = 12'h0fc;
	localparam logic [11:0] REG_STATUS    = 12'h100;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [63:0] PTR_RST       = 64'h0;
	localparam int          CTRL_EN_BIT   = 31;
	localparam int          LEG_REQ_BIT   = 8;
	localparam int          LEG_PRIO_LO   = 16;
	localparam int          LEG_IGN_BIT   = 20;
	localparam int          PTR_LO_BIT    = 12;
	localparam int          PTR_HI_BIT    = 51;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// --------------------------------------------------------------
	// guest register page offsets and fields
	// --------------------------------------------------------------
	localparam logic [11:0] G_TPR         = 12'h080;
	localparam logic [11:0] G_PPR         = 12'h0a0;
	localparam logic [11:0] G_EOI         = 12'h0b0;
	localparam logic [11:0] G_INTERRUPT_COMMAND_LOW        = 12'h300;
	localparam logic [11:0] G_INTERRUPT_COMMAND_HIGH        = 12'h310;
	localparam logic [4:0]  G_ISR_HI      = 5'h02;
	localparam logic [4:0]  G_TMR_HI      = 5'h03;
	localparam logic [4:0]  G_IRR_HI      = 5'h04;
	localparam logic [1:0]  G_EXT_HI      = 2'h1;
	localparam logic [2:0]  MSG_FIXED     = 3'h0;
	localparam int          ICR_MSG_LO    = 8;
	localparam int          ICR_LOGIC_BIT = 11;
	localparam int          ICR_TRIG_BIT  = 15;
	localparam int          ICR_SH_LO     = 18;
	localparam int          ICR_DEST_LO   = 24;
	localparam logic [1:0]  SH_NONE       = 2'b00;
	localparam logic [1:0]  SH_SELF       = 2'b01;
	localparam logic [1:0]  SH_ALL        = 2'b10;
	localparam logic [7:0]  DEST_BCAST    = 8'hff;

	typedef enum logic [2:0] {
		EXIT_NONE    = 3'b000,
		EXIT_PPR_WR  = 3'b001,
		EXIT_EOI_LVL = 3'b010,
		EXIT_IPI     = 3'b011,
		EXIT_PTR     = 3'b100,
		EXIT_OFF     = 3'b101,
		EXIT_EXT     = 3'b110
	} vaa_exit_type;

	typedef struct packed {
		logic        req;
		logic        wr;
		logic [11:0] off;
		logic [31:0] data;
	} vaa_guest_req_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] vector;
		logic [7:0] dest;
		logic       logical;
		logic       broadcast;
	} vaa_ipi_type;
endpackage

// ---- hdl/vaa_core.sv ----
// virtual interrupt controller assist: control block over axi4-lite,
// guest register page with accelerated priority, eoi and command handling
// assumes guest accesses, core priority writes and entry pulses share aclk
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vaa_core
	import vaa_pkg::*;
#(
	parameter int PA_BITS = 48
) (
	input  logic              aclk,
	input  logic              aresetn,
	input  logic [11:0]       s_axi_awaddr,
	input  logic              s_axi_awvalid,
	output logic              s_axi_awready,
	input  logic [31:0]       s_axi_wdata,
	input  logic [3:0]        s_axi_wstrb,
	input  logic              s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  logic              s_axi_bready,
	input  logic [11:0]       s_axi_araddr,
	input  logic              s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  logic              s_axi_rready,
	input  vaa_guest_req_type guest,
	output logic              guest_ack,
	output logic [31:0]       guest_rdata,
	input  logic              prio_ctl_wr,
	input  logic [3:0]        prio_ctl_data,
	input  logic              guest_entry,
	input  logic              intr_take,
	output logic              intr_valid,
	output logic [7:0]        intr_vector,
	output logic [3:0]        virtual_priority_shadow,
	output vaa_ipi_type       ipi,
	output logic              hypervisor_exit,
	output vaa_exit_type      exit_reason,
	output logic [7:0]        last_core_index
);
	// --------------------------------------------------------------
	// storage
	// --------------------------------------------------------------
	logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]        bresp_ff, rresp_ff;
	logic [11:0]       awaddr_ff;
	logic [31:0]       wdata_ff, rdata_ff;
	logic [3:0]        wstrb_ff;
	logic [31:0]       ctrl_ff, leg_vec_ff;
	logic [63:0]       bar_ff, back_ff, log_ff, phy_ff;
	logic [7:0]        tpr_ff, ppr_ff;
	logic [255:0]      isr_ff, tmr_ff, irr_ff;
	logic [31:0]       interrupt_command_low_ff, interrupt_command_high_ff;
	logic [31:0]       page_ff [0:63];
	logic [3:0]        shadow_ff;
	logic              ack_ff, exit_ff, ivalid_ff;
	logic [31:0]       grdata_ff;
	logic [7:0]        ivec_ff;
	vaa_exit_type      reason_ff;
	vaa_ipi_type       ipi_ff;

	function automatic logic [8:0] top_bit(input logic [255:0] v);
		logic [8:0] r;
		r = 9'h0;
		for (int i = 0; i < 256; i++) begin
			if (v[i]) begin
				r = {1'b1, 8'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// --------------------------------------------------------------
	// decode of the guest access and the command register
	// --------------------------------------------------------------
	logic        accel_on;
	logic [8:0]  isr_top, irr_top;
	logic [7:0]  nxt_ppr;
	logic [1:0]  sh;
	logic [7:0]  dest, vec;
	logic        icr_ok, dest_bad;
	logic        g_rd, g_wr, g_tpr, g_ppr, g_eoi, g_interrupt_command_low, g_ext, eoi_lvl;
	logic [2:0]  wsel;
	logic [4:0]  gseg;

	assign accel_on = ctrl_ff[CTRL_EN_BIT];
	assign isr_top  = top_bit(isr_ff);
	assign irr_top  = top_bit(irr_ff);
	// bits 3:0 of the offset select bytes inside the word and are dropped
	assign gseg     = guest.off[11:7];
	assign wsel     = guest.off[6:4];
	assign g_rd     = guest.req && !guest.wr && accel_on;
	assign g_wr     = guest.req && guest.wr && accel_on;
	assign g_tpr    = {guest.off[11:4], 4'h0} == G_TPR;
	assign g_ppr    = {guest.off[11:4], 4'h0} == G_PPR;
	assign g_eoi    = {guest.off[11:4], 4'h0} == G_EOI;
	assign g_interrupt_command_low   = {guest.off[11:4], 4'h0} == G_INTERRUPT_COMMAND_LOW;
	assign g_ext    = guest.off[11:10] == G_EXT_HI;
	assign eoi_lvl  = isr_top[8] && tmr_ff[isr_top[7:0]];
	// command fields come from the low word being written and the stored high word
	assign vec      = guest.data[7:0];
	assign sh       = guest.data[ICR_SH_LO +: 2];
	assign dest     = interrupt_command_high_ff[ICR_DEST_LO +: 8];
	assign icr_ok   = guest.data[ICR_MSG_LO +: 3] == MSG_FIXED
		&& !guest.data[ICR_TRIG_BIT];
	assign dest_bad = sh == SH_NONE && !guest.data[ICR_LOGIC_BIT]
		&& dest != DEST_BCAST && dest > phy_ff[7:0];
	// processor priority: the larger of task priority and in-service class
	assign nxt_ppr  = (isr_top[8] && isr_top[7:4] > tpr_ff[7:4])
		? {isr_top[7:4], 4'h0} : tpr_ff;

	// --------------------------------------------------------------
	// axi4-lite write channel
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= '0;
			wdata_ff   <= '0;
			wstrb_ff   <= '0;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				awaddr_ff  <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end else if (bvalid_ff && s_axi_bready) begin
				wready_ff <= 1'b1;
			end
			if (!awready_ff && !wready_ff && !bvalid_ff) begin
				bvalid_ff <= 1'b1;
				case (awaddr_ff)
					REG_CTRL, REG_LEG_VEC, REG_BAR_LO, REG_BAR_HI, REG_BACK_LO,
					REG_BACK_HI, REG_LOG_LO, REG_LOG_HI, REG_PHY_LO,
					REG_PHY_HI: bresp_ff <= RESP_OKAY;
					default: bresp_ff <= RESP_SLVERR;
				endcase
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	logic do_wr;
	assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;

	// pointer fields keep all 64 bits; the range check judges them on entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff    <= CTRL_RST;
			leg_vec_ff <= CTRL_RST;
			bar_ff     <= PTR_RST;
			back_ff    <= PTR_RST;
			log_ff     <= PTR_RST;
			phy_ff     <= PTR_RST;
		end else if (do_wr) begin
			case (awaddr_ff)
				REG_CTRL:    ctrl_ff <= strobe(ctrl_ff, wdata_ff, wstrb_ff);
				REG_LEG_VEC: leg_vec_ff <= strobe(leg_vec_ff, wdata_ff, wstrb_ff);
				REG_BAR_LO:  bar_ff[31:0] <= strobe(bar_ff[31:0], wdata_ff, wstrb_ff);
				REG_BAR_HI:  bar_ff[63:32] <= strobe(bar_ff[63:32], wdata_ff, wstrb_ff);
				REG_BACK_LO: back_ff[31:0] <= strobe(back_ff[31:0], wdata_ff, wstrb_ff);
				REG_BACK_HI: back_ff[63:32] <= strobe(back_ff[63:32], wdata_ff, wstrb_ff);
				REG_LOG_LO:  log_ff[31:0] <= strobe(log_ff[31:0], wdata_ff, wstrb_ff);
				REG_LOG_HI:  log_ff[63:32] <= strobe(log_ff[63:32], wdata_ff, wstrb_ff);
				REG_PHY_LO:  phy_ff[31:0] <= strobe(phy_ff[31:0], wdata_ff, wstrb_ff);
				REG_PHY_HI:  phy_ff[63:32] <= strobe(phy_ff[63:32], wdata_ff, wstrb_ff);
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// axi4-lite read channel
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL:    rdata_ff <= ctrl_ff;
				REG_LEG_VEC: rdata_ff <= leg_vec_ff;
				REG_BAR_LO:  rdata_ff <= bar_ff[31:0];
				REG_BAR_HI:  rdata_ff <= bar_ff[63:32];
				REG_BACK_LO: rdata_ff <= back_ff[31:0];
				REG_BACK_HI: rdata_ff <= back_ff[63:32];
				REG_LOG_LO:  rdata_ff <= log_ff[31:0];
				REG_LOG_HI:  rdata_ff <= log_ff[63:32];
				REG_PHY_LO:  rdata_ff <= phy_ff[31:0];
				REG_PHY_HI:  rdata_ff <= phy_ff[63:32];
				REG_STATUS:  rdata_ff <= {5'h0, reason_ff, isr_top[7:0], 4'h0, shadow_ff,
					ppr_ff};
				default: begin
					rdata_ff <= '0;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// backing page state
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tpr_ff  <= 8'h0;
			isr_ff  <= '0;
			tmr_ff  <= '0;
			irr_ff  <= '0;
			interrupt_command_low_ff <= '0;
			interrupt_command_high_ff <= '0;
		end else begin
			if (intr_take && ivalid_ff && accel_on) begin
				irr_ff[ivec_ff] <= 1'b0;
				isr_ff[ivec_ff] <= 1'b1;
			end
			if (g_wr && !g_ext && !g_ppr) begin
				if (g_tpr) begin
					tpr_ff <= guest.data[7:0];
				end else if (g_eoi) begin
					if (isr_top[8]) begin
						isr_ff[isr_top[7:0]] <= 1'b0;
					end
				end else if (g_interrupt_command_low) begin
					interrupt_command_low_ff <= guest.data;
					if (icr_ok && (sh == SH_SELF || sh == SH_ALL)) begin
						irr_ff[vec] <= 1'b1;
					end
				end else if ({guest.off[11:4], 4'h0} == G_INTERRUPT_COMMAND_HIGH) begin
					interrupt_command_high_ff <= guest.data;
				end else if (gseg == G_TMR_HI) begin
					tmr_ff[{wsel, 5'h0} +: 32] <= guest.data;
				end else if (gseg == G_IRR_HI) begin
					irr_ff[{wsel, 5'h0} +: 32] <= guest.data;
				end else if (gseg == G_ISR_HI) begin
					isr_ff[{wsel, 5'h0} +: 32] <= guest.data;
				end
			end
			// a core priority write lands last, so it wins over a page write
			if (prio_ctl_wr) begin
				tpr_ff <= {prio_ctl_data, 4'h0};
			end
		end
	end

	// general locations below the extended range; no reset, software initialises
	// command and isr, tmr, irr slots land here too but their reads come from their own registers
	always_ff @(posedge aclk) begin
		if (g_wr && !g_ext && !g_tpr && !g_ppr && !g_eoi) begin
			page_ff[guest.off[9:4]] <= guest.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ppr_ff    <= 8'h0;
			shadow_ff <= 4'h0;
		end else begin
			ppr_ff <= nxt_ppr;
			if (prio_ctl_wr) begin
				shadow_ff <= prio_ctl_data;
			end else if (g_wr && g_tpr) begin
				shadow_ff <= guest.data[7:4];
			end
		end
	end

	// --------------------------------------------------------------
	// guest read answer
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_ff    <= 1'b0;
			grdata_ff <= '0;
		end else begin
			ack_ff <= guest.req;
			if (g_rd && !g_ext) begin
				if (g_tpr) begin
					grdata_ff <= {24'h0, tpr_ff};
				end else if (g_ppr) begin
					grdata_ff <= {24'h0, ppr_ff};
				end else if (g_interrupt_command_low) begin
					grdata_ff <= interrupt_command_low_ff;
				end else if ({guest.off[11:4], 4'h0} == G_INTERRUPT_COMMAND_HIGH) begin
					grdata_ff <= interrupt_command_high_ff;
				end else if (gseg == G_ISR_HI) begin
					grdata_ff <= isr_ff[{wsel, 5'h0} +: 32];
				end else if (gseg == G_TMR_HI) begin
					grdata_ff <= tmr_ff[{wsel, 5'h0} +: 32];
				end else if (gseg == G_IRR_HI) begin
					grdata_ff <= irr_ff[{wsel, 5'h0} +: 32];
				end else begin
					grdata_ff <= page_ff[guest.off[9:4]];
				end
			end else begin
				grdata_ff <= '0;
			end
		end
	end

	// --------------------------------------------------------------
	// exits and interprocessor interrupts
	// --------------------------------------------------------------
	logic ptr_bad;
	assign ptr_bad = (back_ff[63:PA_BITS] != '0) || (log_ff[63:PA_BITS] != '0)
		|| (phy_ff[63:PA_BITS] != '0) || (bar_ff[63:PA_BITS] != '0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exit_ff   <= 1'b0;
			reason_ff <= EXIT_NONE;
			ipi_ff    <= '0;
		end else begin
			exit_ff      <= 1'b0;
			ipi_ff.valid <= 1'b0;
			if (guest_entry && accel_on && ptr_bad) begin
				exit_ff   <= 1'b1;
				reason_ff <= EXIT_PTR;
			end else if (guest.req && !accel_on) begin
				exit_ff   <= 1'b1;
				reason_ff <= EXIT_OFF;
			end else if (guest.req && g_ext) begin
				exit_ff   <= 1'b1;
				reason_ff <= EXIT_EXT;
			end else if (g_wr && g_ppr) begin
				exit_ff   <= 1'b1;
				reason_ff <= EXIT_PPR_WR;
			end else if (g_wr && g_eoi && eoi_lvl) begin
				exit_ff   <= 1'b1;
				reason_ff <= EXIT_EOI_LVL;
			end else if (g_wr && g_interrupt_command_low) begin
				if (!icr_ok || dest_bad) begin
					exit_ff   <= 1'b1;
					reason_ff <= EXIT_IPI;
				end else if (sh != SH_SELF) begin
					ipi_ff.valid     <= 1'b1;
					ipi_ff.vector    <= vec;
					ipi_ff.dest      <= dest;
					ipi_ff.logical   <= guest.data[ICR_LOGIC_BIT];
					ipi_ff.broadcast <= sh != SH_NONE || dest == DEST_BCAST;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// delivery to the guest
	// --------------------------------------------------------------
	// uses the registered priority, so a fresh eoi shows one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ivalid_ff <= 1'b0;
			ivec_ff   <= 8'h0;
		end else if (accel_on) begin
			ivalid_ff <= irr_top[8] && irr_top[7:4] > ppr_ff[7:4]
				&& !(intr_take && ivalid_ff);
			ivec_ff   <= irr_top[7:0];
		end else begin
			ivalid_ff <= ctrl_ff[LEG_REQ_BIT] && (ctrl_ff[LEG_IGN_BIT]
				|| ctrl_ff[LEG_PRIO_LO +: 4] > shadow_ff);
			ivec_ff   <= leg_vec_ff[7:0];
		end
	end

	assign s_axi_awready           = awready_ff;
	assign s_axi_wready            = wready_ff;
	assign s_axi_bvalid            = bvalid_ff;
	assign s_axi_bresp             = bresp_ff;
	assign s_axi_arready           = arready_ff;
	assign s_axi_rvalid            = rvalid_ff;
	assign s_axi_rdata             = rdata_ff;
	assign s_axi_rresp             = rresp_ff;
	assign guest_ack               = ack_ff;
	assign guest_rdata             = grdata_ff;
	assign intr_valid              = ivalid_ff;
	assign intr_vector             = ivec_ff;
	assign virtual_priority_shadow = shadow_ff;
	assign ipi                     = ipi_ff;
	assign hypervisor_exit         = exit_ff;
	assign exit_reason             = reason_ff;
	assign last_core_index         = phy_ff[7:0];
endmodule

// ---- verif/vaa_monitor.sv ----
// checker of guest page, priority, command and exit timing
// assumes it is bound onto vaa_core and shares its clock
`timescale 1ns/1ps
module vaa_monitor
	import vaa_pkg::*;
(
	input logic              aclk,
	input logic              aresetn,
	input vaa_guest_req_type guest,
	input logic              guest_ack,
	input logic              prio_ctl_wr,
	input logic [3:0]        prio_ctl_data,
	input logic              intr_take,
	input logic              intr_valid,
	input logic [3:0]        virtual_priority_shadow,
	input vaa_ipi_type       ipi,
	input logic              hypervisor_exit,
	input vaa_exit_type      exit_reason
);
	logic tw;
	logic pw;
	logic iw;
	assign tw = guest.req && guest.wr && guest.off[11:4] == G_TPR[11:4];
	assign pw = guest.req && guest.wr && guest.off[11:4] == G_PPR[11:4];
	assign iw = guest.req && guest.wr && guest.off[11:4] == G_INTERRUPT_COMMAND_LOW[11:4];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// --------
	// properties
	// --------
	guest_ack_a: assert property (guest_ack == $past(guest.req))
		else $error("guest ack not one cycle after request");
	tpr_copy_a: assert property (tw && !prio_ctl_wr |=> hypervisor_exit ||
		virtual_priority_shadow == $past(guest.data[7:4])) else $error("shadow not copied");
	core_prio_a: assert property (prio_ctl_wr |=>
		virtual_priority_shadow == $past(prio_ctl_data)) else $error("core priority lost");
	ppr_exit_a: assert property (pw |=> hypervisor_exit)
		else $error("priority write without exit");
	ipi_cause_a: assert property (ipi.valid |-> $past(iw))
		else $error("command without low write");
	ipi_no_exit_a: assert property (ipi.valid |-> !hypervisor_exit)
		else $error("delivery and exit together");
	exit_code_a: assert property (hypervisor_exit |-> exit_reason != EXIT_NONE)
		else $error("exit without reason");
	take_drop_a: assert property (intr_take && intr_valid |=> !intr_valid)
		else $error("taken interrupt still offered");
endmodule

bind vaa_core vaa_monitor u_mon (
	.aclk(aclk), .aresetn(aresetn), .guest(guest), .guest_ack(guest_ack),
	.prio_ctl_wr(prio_ctl_wr), .prio_ctl_data(prio_ctl_data), .intr_take(intr_take),
	.intr_valid(intr_valid), .virtual_priority_shadow(virtual_priority_shadow), .ipi(ipi),
	.hypervisor_exit(hypervisor_exit), .exit_reason(exit_reason)
);

// ---- verif/vaa_cpu_model.sv ----
// model of the core that accepts offered virtual interrupts
// assumes intr_take is sampled at the rising edge of aclk
`timescale 1ns/1ps
module vaa_cpu_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic intr_valid,
	input wire logic slow,
	output logic     intr_take
);
	logic [3:0] wait_ff;
	// slow mode lets the offer stand a while, as a busy core would
	always_ff @(posedge aclk) begin
		if (!aresetn || !intr_valid || intr_take) begin
			wait_ff   <= slow ? 4'h5 : 4'h0;
			intr_take <= 1'b0;
		end else if (wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end else begin
			intr_take <= 1'b1;
		end
	end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench of the interrupt controller assist
// assumes vaa_core, vaa_monitor and vaa_cpu_model compiled before
`timescale 1ns/1ps
module testbench;
	import vaa_pkg::*;
	logic              aclk, aresetn, slow, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic              s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic              s_axi_arready, s_axi_rvalid, s_axi_rready, guest_ack, prio_ctl_wr;
	logic              guest_entry, intr_take, intr_valid, hypervisor_exit;
	logic [11:0]       s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, guest_rdata, d;
	logic [3:0]        s_axi_wstrb, prio_ctl_data, virtual_priority_shadow;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [7:0]        intr_vector, last_core_index, v;
	vaa_guest_req_type guest;
	vaa_ipi_type       ipi;
	vaa_exit_type      exit_reason;
	logic [33:0]       qa[$], qb[$], qg[$], qe[$], qi[$], qv[$];
	logic [11:0]       pr[4] = '{REG_BAR_LO, REG_BACK_LO, REG_LOG_LO, REG_PHY_LO};
	int                error_cnt = 0, compares = 0, cyc = 0;

	vaa_core #(.PA_BITS(48)) uut (.*);
	vaa_cpu_model u_cpu (.aclk(aclk), .aresetn(aresetn), .intr_valid(intr_valid),
		.slow(slow), .intr_take(intr_take));

	task chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// --------
	// bus and guest drivers
	// --------
	task bus(input logic w, input logic [11:0] a, input logic [31:0] dd, input logic [33:0] e);
		logic ra, rw, rb;
		if (!w) qa.push_back(e);
		if (w) qb.push_back(e);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= dd;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		rb = 1'b0;
		while (!rb) begin
			@(negedge aclk);
			ra = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
			rw = s_axi_wvalid && s_axi_wready;
			rb = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
			@(posedge aclk);
			if (ra) s_axi_awvalid <= 1'b0;
			if (ra) s_axi_arvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// reads expect data, writes and exits a zero word
	task ga(input logic w, input logic [11:0] o, input logic [31:0] dd, input logic [31:0] e,
		input vaa_exit_type x);
		qg.push_back(e);
		if (x != EXIT_NONE) qe.push_back(x);
		guest <= '{1'b1, w, o, dd};
		@(posedge aclk);
		guest.req <= 1'b0;
		@(posedge aclk);
	endtask
	task entry();
		guest_entry <= 1'b1;
		@(posedge aclk);
		guest_entry <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	// --------
	// result watcher
	// --------
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, qa.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, qb.pop_front());
		if (guest_ack) chk({2'h0, guest_rdata}, qg.pop_front());
		if (hypervisor_exit) chk(exit_reason, qe.size() ? qe.pop_front() : 34'h7);
		if (ipi.valid) chk(ipi[17:0], qi.size() ? qi.pop_front() : '1);
		if (intr_take && intr_valid) chk(intr_vector, qv.size() ? qv.pop_front() : '1);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{prio_ctl_wr, guest_entry, aresetn, prio_ctl_data, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		guest = '0;
		void'($urandom(65321));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		bus(0, REG_CTRL, 0, {RESP_OKAY, CTRL_RST});
		bus(0, 12'h040, 0, {RESP_SLVERR, 32'h0});
		bus(1, 12'h040, 32'h1, {RESP_SLVERR, 32'h0});
		ga(1, G_TPR, 32'h5a, 0, EXIT_OFF);
		bus(1, REG_LEG_VEC, 32'h33, 0);
		bus(1, REG_CTRL, 32'h8011_0100, 0); // legacy request ignored, acceleration enabled
		foreach (pr[i]) begin
			d = $urandom() & 32'hffff_f000;
			if (i == 3) d = d | 32'h3; // only the index may sit below bit 12
			bus(1, pr[i], d, 0);
			bus(1, pr[i] + 12'h4, $urandom() & 32'hffff, 0);
			bus(0, pr[i], 0, {RESP_OKAY, d});
		end
		chk(last_core_index, 34'h3);
		entry();
		bus(1, REG_LOG_HI, 32'h0001_0000, 0);
		qe.push_back(EXIT_PTR);
		entry(); // log pointer now has bit 48 set, so this entry exits with EXIT_PTR
		bus(1, REG_LOG_HI, 0, 0);
		ga(1, G_TPR, 32'h5a, 0, EXIT_NONE);
		chk(virtual_priority_shadow, 34'h5);
		ga(0, G_TPR, 0, 32'h5a, EXIT_NONE);
		prio_ctl_data <= 4'h7;
		prio_ctl_wr <= 1'b1;
		@(posedge aclk);
		prio_ctl_wr <= 1'b0;
		@(posedge aclk);
		ga(0, G_TPR, 0, 32'h70, EXIT_NONE);
		ga(1, G_PPR, 32'hff, 0, EXIT_PPR_WR);
		ga(0, G_PPR, 0, 32'h70, EXIT_NONE);
		v = {2'b01, 6'($urandom())};
		ga(1, G_INTERRUPT_COMMAND_HIGH, 32'h0200_0000, 0, EXIT_NONE);
		qi.push_back({v, 8'h02, 1'b0, 1'b0});
		ga(1, G_INTERRUPT_COMMAND_LOW, {24'h0, v}, 0, EXIT_NONE);
		qi.push_back({v, 8'h02, 1'b1, 1'b0});
		ga(1, G_INTERRUPT_COMMAND_LOW, {20'h0, 4'h8, v}, 0, EXIT_NONE);
		qi.push_back({v, 8'h02, 1'b0, 1'b1});
		ga(1, G_INTERRUPT_COMMAND_LOW, {12'h0, 4'h8, 8'h0, v}, 0, EXIT_NONE);
		ga(0, {4'h2, 1'b0, v[7:5], 4'h0}, 0, 32'h1 << v[4:0], EXIT_NONE);
		ga(0, G_INTERRUPT_COMMAND_HIGH, 0, 32'h0200_0000, EXIT_NONE);
		ga(1, G_INTERRUPT_COMMAND_HIGH, 32'h0500_0000, 0, EXIT_NONE);
		ga(1, G_INTERRUPT_COMMAND_LOW, {24'h0, v}, 0, EXIT_IPI);
		for (int m = 1; m < 8; m++) ga(1, G_INTERRUPT_COMMAND_LOW, {21'h0, m[2:0], v}, 0, EXIT_IPI);
		ga(1, G_INTERRUPT_COMMAND_LOW, {16'h0, 8'h80, v}, 0, EXIT_IPI);
		slow <= 1'($urandom());
		qv.push_back(8'h95);
		ga(1, G_INTERRUPT_COMMAND_LOW, 32'h0004_0095, 0, EXIT_NONE);
		repeat (12) @(posedge aclk);
		ga(0, G_PPR, 0, 32'h90, EXIT_NONE);
		ga(0, 12'h140, 0, 32'h0020_0000, EXIT_NONE);
		ga(1, G_EOI, 0, 0, EXIT_NONE);
		ga(0, 12'h140, 0, 0, EXIT_NONE);
		ga(0, G_PPR, 0, 32'h70, EXIT_NONE);
		ga(1, 12'h170, 1, 0, EXIT_NONE);
		ga(1, 12'h1f0, 1, 0, EXIT_NONE);
		ga(1, G_EOI, 0, 0, EXIT_EOI_LVL);
		ga(0, 12'h170, 0, 0, EXIT_NONE);
		ga(1, 12'h400, 1, 0, EXIT_EXT);
		ga(1, 12'h3f0, 32'h1234_5678, 0, EXIT_NONE);
		ga(0, 12'h3f0, 0, 32'h1234_5678, EXIT_NONE);
		repeat (4) @(posedge aclk);
		chk(34'(qa.size() + qb.size() + qg.size() + qe.size() + qi.size() + qv.size()), 34'h0);
		conclude();
	end
endmodule
